// *** verilog/uart_power_consts.vh ***
// Constants for the power-gated serial transmit/receive unit
`ifndef UART_POWER_CONSTS_VH
`define UART_POWER_CONSTS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define FMC_ADDR 16'hff50
`define FMC_RESET 8'h01
`define TXB_ADDR 16'hff55
`define RXB_ADDR 16'hff52
`define STS_ADDR 16'hff53
`define FLG_ADDR 16'hff54
`define CTL_ADDR 16'hff57
// ----------------------------------------
// Field positions in the frame mode register
// ----------------------------------------
`define FMC_POWER 7
`define FMC_TXE 6
`define FMC_RXE 5
`define FMC_PS_HI 4
`define FMC_PS_LO 3
`define FMC_CL 2
`define FMC_SL 1
// ----------------------------------------
// Control register fields and baud
// ----------------------------------------
`define CTL_BRK_RX 7
`define CTL_BRK_TX 6
`define CTL_INV 1
`define BAUD_DIV_DEFAULT 16'h0082
`define ZERO8 8'h00
`endif

// *** verilog/uart_power_tx.v ***
// Power-gated serial transmit/receive unit with frame mode register
`default_nettype none
`include "uart_power_consts.vh"
module uart_power_tx #(
  parameter [15:0] BAUD_DIV = `BAUD_DIV_DEFAULT
) (
  input wire ref_clk,
  input wire reset,
  input wire [15:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire [7:0] cpu_wmask,
  input wire cpu_wr,
  output reg [7:0] cpu_rdata,
  input wire serial_input_pin,
  output wire serial_output_pin,
  output wire serial_output_en,
  output wire pins_released,
  output reg transmit_done_interrupt,
  output reg rx_byte_valid
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] frame_mode_control; // Mode, enables and format
  reg [7:0] serial_control_register; // Break bits and invert
  reg [7:0] transmit_holding_buffer;
  reg [10:0] transmit_shift_register; // Data, parity, stop bits
  reg [3:0] tx_bits_left; // Bits still to send
  reg [15:0] tx_baud_cnt;
  reg tx_busy;
  reg tx_line; // Uninverted line level
  reg [1:0] transmit_status_flags; // Bit1 buffer full, bit0 shifting
  reg [7:0] receive_holding_buffer;
  reg [2:0] receive_error_flags;
  reg rx_meta_reg, rx_sync_reg; // Two-stage input synchroniser
  reg rx_busy;
  reg [3:0] rx_bit_idx;
  reg [15:0] rx_baud_cnt;
  reg [7:0] rx_shift;

  wire power_on = frame_mode_control[`FMC_POWER];
  wire tx_en = power_on & frame_mode_control[`FMC_TXE];
  wire rx_en = power_on & frame_mode_control[`FMC_RXE];
  wire [1:0] parity_sel = frame_mode_control[`FMC_PS_HI:`FMC_PS_LO];
  wire eight_bit = frame_mode_control[`FMC_CL];
  wire two_stop = frame_mode_control[`FMC_SL];
  // Input seen as high while unpowered
  wire rx_in = power_on ? rx_sync_reg : 1'b1;

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // Released as port pins when all three bits are clear
  assign pins_released = ~(frame_mode_control[`FMC_POWER] | frame_mode_control[`FMC_TXE] |
    frame_mode_control[`FMC_RXE]);
  assign serial_output_en = ~pins_released;
  // Unpowered forces the line high; invert only applies while powered
  assign serial_output_pin = power_on ?
    (tx_line ^ serial_control_register[`CTL_INV]) : 1'b1;

  // ----------------------------------------
  // Frame assembly
  // ----------------------------------------
  wire [7:0] tx_data = eight_bit ? transmit_holding_buffer : {1'b0, transmit_holding_buffer[6:0]};
  wire odd_par = ~(^tx_data);
  reg par_bit;
  reg has_par;
  always @* begin
    // Parity bit from the selected mode
    has_par = (parity_sel != 2'b00);
    case (parity_sel)
      2'b01: par_bit = 1'b0;
      2'b10: par_bit = odd_par;
      2'b11: par_bit = ~odd_par;
      default: par_bit = 1'b0;
    endcase
  end
  // Bits after start: data, optional parity, one or two stops
  wire [3:0] frame_len = (eight_bit ? 4'h8 : 4'h7) + {3'b000, has_par} + (two_stop ? 4'h2 : 4'h1);
  reg [10:0] frame_bits;
  always @* begin
    // Pack data LSB first, then parity, then stop ones
    frame_bits = 11'h7ff;
    if (eight_bit) begin
      frame_bits[7:0] = tx_data;
      if (has_par) frame_bits[8] = par_bit;
    end else begin
      frame_bits[6:0] = tx_data[6:0];
      if (has_par) frame_bits[7] = par_bit;
    end
  end

  wire txb_write = cpu_wr && (cpu_addr == `TXB_ADDR);
  wire tx_tick = (tx_baud_cnt == BAUD_DIV - 16'h0001);

  // ----------------------------------------
  // Frame mode and control registers
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (reset) begin
      frame_mode_control <= `FMC_RESET;
      serial_control_register <= `ZERO8;
    end else begin
      // Bit mask lets single-bit and byte writes share one path
      if (cpu_wr && cpu_addr == `FMC_ADDR)
        frame_mode_control <= (frame_mode_control & ~cpu_wmask) |
          (cpu_wdata & cpu_wmask);
      if (cpu_wr && cpu_addr == `CTL_ADDR)
        serial_control_register <= (serial_control_register & ~cpu_wmask) |
          (cpu_wdata & cpu_wmask);
      if (!power_on) begin
        serial_control_register[`CTL_BRK_RX] <= 1'b0;
        serial_control_register[`CTL_BRK_TX] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  // Powering down acts as the reset of the clock-gated logic
  always @(posedge ref_clk) begin
    transmit_done_interrupt <= 1'b0;
    if (reset || !power_on) begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tx_baud_cnt <= 16'h0000;
      tx_bits_left <= 4'h0;
      transmit_shift_register <= 11'h7ff;
      transmit_status_flags <= 2'b00;
      transmit_holding_buffer <= `ZERO8;
    end else if (!tx_en) begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tx_baud_cnt <= 16'h0000;
      transmit_status_flags <= 2'b00;
    end else if (!tx_busy) begin
      // Stays idle high until a buffer write arrives
      tx_line <= 1'b1;
      if (txb_write) begin
        transmit_holding_buffer <= cpu_wdata;
        transmit_status_flags <= 2'b11;
      end else if (transmit_status_flags[1]) begin
        transmit_shift_register <= frame_bits;
        tx_bits_left <= frame_len;
        tx_line <= 1'b0; // Start bit
        tx_busy <= 1'b1;
        tx_baud_cnt <= 16'h0000;
        transmit_status_flags <= 2'b01;
      end
    end else begin
      tx_baud_cnt <= tx_tick ? 16'h0000 : tx_baud_cnt + 16'h0001;
      if (tx_tick) begin
        if (tx_bits_left == 4'h0) begin
          // Last stop bit has just completed
          tx_busy <= 1'b0;
          transmit_status_flags <= 2'b00;
          transmit_done_interrupt <= 1'b1;
        end else begin
          tx_line <= transmit_shift_register[0];
          transmit_shift_register <= {1'b1, transmit_shift_register[10:1]};
          tx_bits_left <= tx_bits_left - 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  always @(posedge ref_clk) begin
    // Pin synchroniser runs regardless of power
    if (reset) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= serial_input_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  wire [3:0] rx_last = eight_bit ? 4'h8 : 4'h7;
  always @(posedge ref_clk) begin
    // Single stop bit always; framing error if the stop is low
    rx_byte_valid <= 1'b0;
    if (reset || !power_on) begin
      rx_busy <= 1'b0;
      rx_bit_idx <= 4'h0;
      rx_baud_cnt <= 16'h0000;
      rx_shift <= `ZERO8;
      receive_holding_buffer <= `ZERO8;
      receive_error_flags <= 3'b000;
    end else if (!rx_en) begin
      rx_busy <= 1'b0;
      rx_bit_idx <= 4'h0;
      rx_baud_cnt <= 16'h0000;
    end else if (!rx_busy) begin
      if (!rx_in) begin
        rx_busy <= 1'b1;
        rx_bit_idx <= 4'h0;
        rx_baud_cnt <= BAUD_DIV >> 1; // Sample mid-bit
      end
    end else if (rx_baud_cnt == BAUD_DIV - 16'h0001) begin
      rx_baud_cnt <= 16'h0000;
      rx_bit_idx <= rx_bit_idx + 4'h1;
      if (rx_bit_idx == 4'h0) begin
        if (rx_in) rx_busy <= 1'b0; // False start
      end else if (rx_bit_idx <= rx_last) begin
        rx_shift <= {rx_in, rx_shift[7:1]};
      end else begin
        rx_busy <= 1'b0;
        rx_byte_valid <= 1'b1;
        receive_holding_buffer <= eight_bit ? rx_shift : {1'b0, rx_shift[7:1]};
        receive_error_flags[1] <= ~rx_in;
      end
    end else begin
      rx_baud_cnt <= rx_baud_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    case (cpu_addr)
      `FMC_ADDR: cpu_rdata = frame_mode_control;
      `TXB_ADDR: cpu_rdata = transmit_holding_buffer;
      `RXB_ADDR: cpu_rdata = receive_holding_buffer;
      `STS_ADDR: cpu_rdata = {5'b00000, receive_error_flags};
      `FLG_ADDR: cpu_rdata = {6'b000000, transmit_status_flags};
      `CTL_ADDR: cpu_rdata = serial_control_register;
      default: cpu_rdata = `ZERO8;
    endcase
  end
endmodule
`default_nettype wire

// *** tb/uart_power_tx_chk.sv ***
// Checker for the power-gated serial unit
`default_nettype none
`include "uart_power_consts.vh"
module uart_power_tx_chk #(
  parameter [15:0] BAUD_DIV = 16'h0082
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_wmask,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_rdata,
  input wire logic serial_input_pin,
  input wire logic serial_output_pin,
  input wire logic serial_output_en,
  input wire logic pins_released,
  input wire logic transmit_done_interrupt,
  input wire logic rx_byte_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic pwr_q; // Shadow of the power bit, kept from bus writes
  always @(posedge ref_clk) begin
    if (reset) pwr_q <= 1'b0;
    else if (cpu_wr && cpu_addr == `FMC_ADDR)
      pwr_q <= (cpu_wdata[7] & cpu_wmask[7]) | (pwr_q & ~cpu_wmask[7]);
  end
  sequence s_fmc_wr;
    cpu_wr && cpu_addr == `FMC_ADDR && cpu_wmask == 8'hff;
  endsequence
  sequence s_off;
    (!pwr_q) [*3];
  endsequence
  AST_STOP_PINS: assert property (
    cpu_addr == `FMC_ADDR |-> pins_released == (cpu_rdata[7:5] == 3'h0)) else $error("pin release");
  AST_OUT_EN: assert property (
    serial_output_en != pins_released) else $error("output enable");
  AST_RESET_VAL: assert property (
    $past(reset) && cpu_addr == `FMC_ADDR |-> cpu_rdata == `FMC_RESET) else $error("reset value");
  AST_BYTE_WR: assert property (
    s_fmc_wr ##1 cpu_addr == `FMC_ADDR |-> cpu_rdata == $past(cpu_wdata)) else $error("byte write");
  AST_PWR_HIGH: assert property (
    !pwr_q && !$past(pwr_q) |-> serial_output_pin) else $error("line not high");
  AST_PWR_QUIET: assert property (
    s_off |-> !transmit_done_interrupt && !rx_byte_valid) else $error("activity while off");
  AST_DONE_LINE: assert property (
    transmit_done_interrupt |-> serial_output_pin ##1 !transmit_done_interrupt) else $error("done");
  AST_BIT_LEN: assert property (disable iff (reset || !pwr_q)
    $fell(serial_output_pin) |=> (!serial_output_pin) [*3]) else $error("bit too short");
endmodule
bind uart_power_tx uart_power_tx_chk #(.BAUD_DIV(BAUD_DIV)) chk_u (.ref_clk(ref_clk),
  .reset(reset), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask),
  .cpu_wr(cpu_wr), .cpu_rdata(cpu_rdata), .serial_input_pin(serial_input_pin),
  .serial_output_pin(serial_output_pin), .serial_output_en(serial_output_en),
  .pins_released(pins_released), .transmit_done_interrupt(transmit_done_interrupt),
  .rx_byte_valid(rx_byte_valid));
`default_nettype wire

// *** tb/serial_peer.sv ***
// Remote serial peer: captures frames, sends 8N1 bytes
`default_nettype none
module serial_peer #(
  parameter int BAUD = 4
) (
  input wire logic ref_clk,
  input wire logic line_in,
  input wire logic [3:0] n_bits,
  output logic [11:0] got,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial line_out = 1'b1; // Line idles high
  // Sample mid-bit after each start edge, first bit into bit 0
  always begin
    @(negedge line_in);
    got = 12'h000;
    repeat (BAUD / 2) @(posedge ref_clk);
    for (int i = 0; i < n_bits; i++) begin
      repeat (BAUD) @(posedge ref_clk);
      got[i] = line_in;
    end
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      #1 line_out = f[i];
      repeat (BAUD) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// *** tb/uart_power_and_transmit_control_tb_top.sv ***
// Self-checking bench for the power-gated serial unit
`default_nettype none
`include "uart_power_consts.vh"
module uart_power_and_transmit_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BD = 4; // Short baud divider keeps frames brief
  logic ref_clk = 1'b0, reset = 1'b1, cpu_wr = 1'b0, hit;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00, cpu_wmask = 8'h00;
  logic [3:0] n_bits = 4'h9;
  wire [7:0] cpu_rdata;
  wire [11:0] got;
  wire sout, sen, rel, done, rxv, rx_line;
  int n_fail = 0, num_checks = 0, n_rx = 0;
  typedef struct { logic [7:0] fmc, data; logic [3:0] n; logic [11:0] exp; } row_t;
  row_t rows [4] = '{'{8'h05, 8'ha5, 4'h9, 12'h1a5}, '{8'h0b, 8'h3c, 4'ha, 12'h33c},
    '{8'h15, 8'h81, 4'ha, 12'h381}, '{8'h1b, 8'h5a, 4'ha, 12'h35a}};
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (rxv === 1'b1) n_rx++;
  uart_power_tx #(.BAUD_DIV(16'h0004)) dut_u (.ref_clk(ref_clk), .reset(reset),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask), .cpu_wr(cpu_wr),
    .cpu_rdata(cpu_rdata), .serial_input_pin(rx_line), .serial_output_pin(sout),
    .serial_output_en(sen), .pins_released(rel), .transmit_done_interrupt(done),
    .rx_byte_valid(rxv));
  serial_peer #(.BAUD(BD)) peer_u (.ref_clk(ref_clk), .line_in(sout), .n_bits(n_bits),
    .got(got), .line_out(rx_line));
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge ref_clk);
    #1 cpu_addr = a; cpu_wdata = d; cpu_wmask = m; cpu_wr = 1'b1;
    @(posedge ref_clk);
    #1 cpu_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    cpu_addr = a;
    #1 chk(cpu_rdata, e);
  endtask
  task automatic wait_done(output logic h);
    h = 1'b0;
    for (int i = 0; i < 200 && !h; i++) begin
      @(posedge ref_clk);
      #1 h = (done === 1'b1);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 reset = 1'b0;
    rd(`FMC_ADDR, `FMC_RESET);
    chk(rel, 1'b1);
    foreach (rows[i]) begin
      n_bits = rows[i].n;
      wr(`FMC_ADDR, rows[i].fmc | 8'h80, 8'hff);
      wr(`FMC_ADDR, 8'h40, 8'h40);
      rd(`FMC_ADDR, rows[i].fmc | 8'hc0);
      chk({rel, sen}, 2'h1);
      wr(`TXB_ADDR, rows[i].data, 8'hff);
      repeat (2) @(posedge ref_clk);
      #1 chk(sout, 1'b0);
      wait_done(hit);
      chk(hit, 1'b1);
      chk(got, rows[i].exp);
      repeat (3 * BD) @(posedge ref_clk);
      #1 chk(sout, 1'b1);
      wr(`FMC_ADDR, 8'h00, 8'h40);
      wr(`FMC_ADDR, 8'h00, 8'h80);
      chk(rel, 1'b1);
      $display("row %0d done", i);
    end
    // Buffer write with transmit disabled is ignored
    wr(`FMC_ADDR, 8'h85, 8'hff);
    wr(`TXB_ADDR, 8'h55, 8'hff);
    wait_done(hit);
    chk({hit, sout}, 2'h1);
    // Power dropped in mid-frame, break bits and shift flag set beforehand
    wr(`CTL_ADDR, 8'hc0, 8'hc0);
    rd(`CTL_ADDR, 8'hc0);
    wr(`FMC_ADDR, 8'h40, 8'h40);
    wr(`TXB_ADDR, 8'h00, 8'hff);
    repeat (3 * BD) @(posedge ref_clk);
    #1 rd(`FLG_ADDR, 8'h01);
    wr(`FMC_ADDR, 8'h01, 8'hff);
    repeat (2) @(posedge ref_clk);
    #1 chk(sout, 1'b1);
    wait_done(hit);
    chk(hit, 1'b0);
    rd(`FLG_ADDR, 8'h00);
    cpu_addr = `CTL_ADDR;
    #1 chk(cpu_rdata[7:6], 2'h0);
    $display("power tests done");
    // Receive ignored while off, taken once enabled
    peer_u.send(8'hc3);
    #1 chk(n_rx, 0);
    wr(`FMC_ADDR, 8'h85, 8'hff);
    wr(`FMC_ADDR, 8'h20, 8'h20);
    peer_u.send(8'h3c);
    repeat (2 * BD) @(posedge ref_clk);
    #1 chk(n_rx, 1);
    rd(`RXB_ADDR, 8'h3c);
    wr(`FMC_ADDR, 8'h00, 8'h20);
    wr(`FMC_ADDR, 8'h85, 8'hff);
    rd(`RXB_ADDR, 8'h3c);
    wr(`FMC_ADDR, 8'h05, 8'h80);
    // Power-off clears the buffer on the edge after the write
    @(posedge ref_clk);
    #1 rd(`RXB_ADDR, 8'h00);
    // Reset in mid-run
    @(posedge ref_clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 reset = 1'b0;
    rd(`FMC_ADDR, `FMC_RESET);
    $display("receive and reset tests done");
    close_out();
  end
  initial begin
    #1000000;
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
